/* epvl_top.sv */
// Exception priority resolution and vector address logic with AHB-Lite registers
// How it works
// - Table word 0 holds initial stack pointer, then handler addresses by exception number.
// - Vector address is table base plus four times the exception number.
// - Reset puts the table base back at address zero.
// - Table offset writes are aligned to 256 bytes within the allowed range.
// - Smaller value wins; reset, hard fault and NMI are fixed, others programmable.
// - Every programmable priority resets to zero.
// - Programmable priorities are three bits, below all fixed negative levels.
// - Equal priorities resolve to the smallest exception number.
// - Only a strictly higher priority preempts; equal ones stay pending.
// - Each priority entry splits into group and subpriority by the grouping setting.
// - Preemption compares group priority only.
// - Equal group: smaller subpriority first, then lowest interrupt number.
// - Interrupts 0..29 map to bits; 8, 9, 13, 26, 27 have no source.
// - NMI is always enabled at level -2, beaten only by reset.
// - Hard fault sits at level -1, above all programmable exceptions.
//
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps

module epvl_top
	import epvl_pkg::*;
(
	// Clock and reset
	input  wire logic                i_clk,
	input  wire logic                i_reset_n,
	// AHB-Lite slave
	input  wire logic                i_hsel,
	input  wire logic [31:0]         i_haddr,
	input  wire logic [1:0]          i_htrans,
	input  wire logic                i_hwrite,
	input  wire logic [2:0]          i_hsize,
	input  wire logic [31:0]         i_hwdata,
	input  wire logic                i_hready,
	output logic      [31:0]         o_hrdata,
	output logic                     o_hreadyout,
	output logic                     o_hresp,
	// Exception sources
	input  wire logic [NUM_IRQ-1:0]  i_irq,
	input  wire logic                i_nmi,
	input  wire logic                i_hard_fault,
	input  wire logic [NUM_SYS-1:0]  i_sys_pend,
	// Core side
	input  wire logic [5:0]          i_active_num,
	input  wire logic                i_take,
	input  wire logic [5:0]          i_take_num,
	output logic                     o_exc_valid,
	output logic [5:0]               o_exc_num,
	output logic [31:0]              o_exc_vector,
	output logic                     o_exc_preempt
);

	// ==========================================================
	// Declarations
	logic [31:0]        vtbl_ff;
	logic [31:0]        nxt_vtbl;
	logic [1:0]         group_ff;
	logic [1:0]         nxt_group;
	logic [PRIO_W-1:0]  irq_prio_ff [NUM_IRQ];
	logic [PRIO_W-1:0]  nxt_irq_prio [NUM_IRQ];
	logic [PRIO_W-1:0]  sys_prio_ff [NUM_SYS];
	logic [PRIO_W-1:0]  nxt_sys_prio [NUM_SYS];
	logic [7:0]         addr_ff;
	logic [7:0]         nxt_addr;
	logic               wr_ff;
	logic               nxt_wr;
	logic [31:0]        rdata_ff;
	logic [31:0]        nxt_rdata;
	logic               ready_ff;
	logic               resp_ff;
	logic [NUM_IRQ-1:0] irq_sync;
	logic [NUM_IRQ-1:0] pend_ff;
	logic [NUM_IRQ-1:0] nxt_pend;
	logic               valid_ff;
	logic               nxt_valid;
	logic [5:0]         num_ff;
	logic [5:0]         nxt_num;
	logic [31:0]        vec_ff;
	logic [31:0]        nxt_vec;
	logic               pre_ff;
	logic               nxt_pre;
	logic               addr_ok;
	logic               wr_now;
	logic [3:0]         best_lvl;
	logic [2:0]         best_sub;
	logic [3:0]         act_lvl;

	// ==========================================================
	// Request synchroniser
	epvl_sync #(
		.WIDTH (NUM_IRQ)
	) u_sync (
		.i_clk     (i_clk),
		.i_reset_n (i_reset_n),
		.i_async   (i_irq),
		.o_sync    (irq_sync)
	);

	// ==========================================================
	// Helpers
	function automatic logic [2:0] sys_slot(input logic [5:0] n);
		case (n)
			EXC_MEM:     sys_slot = 3'h0;
			EXC_BUS:     sys_slot = 3'h1;
			EXC_USAGE:   sys_slot = 3'h2;
			EXC_SVC:     sys_slot = 3'h3;
			EXC_DEBUG:   sys_slot = 3'h4;
			EXC_PEND_SRV: sys_slot = 3'h5;
			EXC_SYSTICK: sys_slot = 3'h6;
			default:     sys_slot = 3'h7;
		endcase
	endfunction

	// Group level of a programmable value; fixed levels sit below LVL_PROG
	function automatic logic [3:0] grp_lvl(input logic [2:0] p, input logic [1:0] split);
		grp_lvl = LVL_PROG + {1'b0, p >> split};
	endfunction

	function automatic logic [2:0] sub_of(input logic [2:0] p, input logic [1:0] split);
		sub_of = p & ~(3'h7 << split);
	endfunction

	// ==========================================================
	// Bus address phase and register writes
	assign addr_ok = i_hsel && (i_htrans == HTRANS_NSEQ) && i_hready;
	assign wr_now  = wr_ff;

	always_comb begin
		nxt_addr     = addr_ok ? i_haddr[7:0] : addr_ff;
		nxt_wr       = addr_ok && i_hwrite;
		nxt_vtbl     = vtbl_ff;
		nxt_group    = group_ff;
		nxt_irq_prio = irq_prio_ff;
		nxt_sys_prio = sys_prio_ff;
		if (wr_now) begin
			case (addr_ff)
				OFF_VTBL:    nxt_vtbl = i_hwdata & VTBL_MASK;
				OFF_GROUP:   nxt_group = i_hwdata[1:0];
				OFF_SYS_PRIO1: begin
					for (int j = 0; j < 3; j++) begin
						nxt_sys_prio[j] = i_hwdata[j*FLD_STRIDE +: PRIO_W];
					end
				end
				OFF_SYS_PRIO2: begin
					for (int j = 0; j < 4; j++) begin
						nxt_sys_prio[j+3] = i_hwdata[j*FLD_STRIDE +: PRIO_W];
					end
				end
				default: begin
					if (addr_ff >= OFF_IPRI0 && addr_ff <= OFF_IPRI7) begin
						for (int j = 0; j < 4; j++) begin
							if (int'(addr_ff - OFF_IPRI0) + j < NUM_IRQ) begin
								nxt_irq_prio[int'(addr_ff - OFF_IPRI0) + j] =
									i_hwdata[j*FLD_STRIDE +: PRIO_W];
							end
						end
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Read data, taken from next values so a read right after a write sees it
	always_comb begin
		nxt_rdata = rdata_ff;
		if (addr_ok && !i_hwrite) begin
			nxt_rdata = 32'h00000000;
			case (i_haddr[7:0])
				OFF_VTBL:    nxt_rdata = nxt_vtbl;
				OFF_GROUP:   nxt_rdata = {30'h00000000, nxt_group};
				OFF_SYS_PRIO1: begin
					for (int j = 0; j < 3; j++) begin
						nxt_rdata[j*FLD_STRIDE +: PRIO_W] = nxt_sys_prio[j];
					end
				end
				OFF_SYS_PRIO2: begin
					for (int j = 0; j < 4; j++) begin
						nxt_rdata[j*FLD_STRIDE +: PRIO_W] = nxt_sys_prio[j+3];
					end
				end
				OFF_PEND:    nxt_rdata = {2'h0, pend_ff};
				OFF_SEL:     nxt_rdata = {24'h000000, pre_ff, valid_ff, num_ff};
				default: begin
					if (i_haddr[7:0] >= OFF_IPRI0 && i_haddr[7:0] <= OFF_IPRI7) begin
						for (int j = 0; j < 4; j++) begin
							if (int'(i_haddr[7:0] - OFF_IPRI0) + j < NUM_IRQ) begin
								nxt_rdata[j*FLD_STRIDE +: PRIO_W] =
									nxt_irq_prio[int'(i_haddr[7:0] - OFF_IPRI0) + j];
							end
						end
					end
				end
			endcase
		end
	end

	// Zero wait states; unmapped reads return zero with OKAY
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			addr_ff  <= 8'h00;
			wr_ff    <= 1'b0;
			rdata_ff <= 32'h00000000;
			ready_ff <= 1'b1;
			resp_ff  <= 1'b0;
			vtbl_ff  <= VTBL_RST;
			group_ff <= GROUP_RST;
			for (int i = 0; i < NUM_IRQ; i++) begin
				irq_prio_ff[i] <= PRIO_RST;
			end
			for (int i = 0; i < NUM_SYS; i++) begin
				sys_prio_ff[i] <= PRIO_RST;
			end
		end else begin
			addr_ff      <= nxt_addr;
			wr_ff        <= nxt_wr;
			rdata_ff     <= nxt_rdata;
			ready_ff     <= 1'b1;
			resp_ff      <= 1'b0;
			vtbl_ff      <= nxt_vtbl;
			group_ff     <= nxt_group;
			irq_prio_ff  <= nxt_irq_prio;
			sys_prio_ff  <= nxt_sys_prio;
		end
	end

	// ==========================================================
	// Pending state of peripheral interrupts
	always_comb begin
		nxt_pend = pend_ff;
		if (i_take && i_take_num >= IRQ_BASE) begin
			nxt_pend[5'(i_take_num - IRQ_BASE)] = 1'b0;
		end
		// A request in the clearing cycle wins over the clear
		nxt_pend = (nxt_pend | irq_sync) & ~IRQ_RSVD;
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pend_ff <= '0;
		end else begin
			pend_ff <= nxt_pend;
		end
	end

	// ==========================================================
	// Arbitration over exception numbers 2 to NUM_EXC-1
	always_comb begin
		logic       v;
		logic [3:0] lv;
		logic [2:0] sb;
		logic [2:0] p;
		v         = 1'b0;
		lv        = LVL_NONE;
		sb        = 3'h0;
		p         = 3'h0;
		nxt_valid = 1'b0;
		nxt_num   = EXC_THREAD;
		best_lvl  = LVL_NONE;
		best_sub  = 3'h7;
		act_lvl   = LVL_NONE;
		for (int n = 2; n < NUM_EXC; n++) begin
			v  = 1'b0;
			lv = LVL_NONE;
			sb = 3'h0;
			if (6'(n) == EXC_NMI) begin
				v  = i_nmi;
				lv = LVL_NMI;
			end else if (6'(n) == EXC_HARD) begin
				v  = i_hard_fault;
				lv = LVL_HARD;
			end else if (6'(n) >= IRQ_BASE) begin
				p  = irq_prio_ff[n - 16];
				v  = pend_ff[n - 16];
				lv = grp_lvl(p, group_ff);
				sb = sub_of(p, group_ff);
			end else if (sys_slot(6'(n)) != 3'h7) begin
				p  = sys_prio_ff[sys_slot(6'(n))];
				v  = i_sys_pend[sys_slot(6'(n))];
				lv = grp_lvl(p, group_ff);
				sb = sub_of(p, group_ff);
			end
			if (6'(n) == i_active_num) begin
				act_lvl = lv;
			end
			// Strict compare keeps the lower number on a tie
			if (v && (!nxt_valid || {lv, sb} < {best_lvl, best_sub})) begin
				nxt_valid = 1'b1;
				nxt_num   = 6'(n);
				best_lvl  = lv;
				best_sub  = sb;
			end
		end
		// Only a strictly better group preempts; thread mode is always preemptible
		nxt_pre = nxt_valid && ((i_active_num == EXC_THREAD) || (best_lvl < act_lvl));
		nxt_vec = vtbl_ff + {24'h000000, nxt_num, 2'h0};
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			valid_ff <= 1'b0;
			num_ff   <= EXC_THREAD;
			vec_ff   <= VTBL_RST;
			pre_ff   <= 1'b0;
		end else begin
			valid_ff <= nxt_valid;
			num_ff   <= nxt_num;
			vec_ff   <= nxt_vec;
			pre_ff   <= nxt_pre;
		end
	end

	// ==========================================================
	// Outputs
	assign o_hrdata      = rdata_ff;
	assign o_hreadyout   = ready_ff;
	assign o_hresp       = resp_ff;
	assign o_exc_valid   = valid_ff;
	assign o_exc_num     = num_ff;
	assign o_exc_vector  = vec_ff;
	assign o_exc_preempt = pre_ff;

endmodule

/* epvl_pkg.sv */
// Package of constants for the exception priority and vector logic
package epvl_pkg;

	// ==========================================================
	// Sizes
	localparam int          NUM_IRQ     = 30;
	localparam int          NUM_SYS     = 7;
	localparam int          PRIO_W      = 3;
	localparam int          NUM_EXC     = 46;
	localparam logic [5:0]  IRQ_BASE    = 6'h10;

	// ==========================================================
	// Exception numbers
	localparam logic [5:0]  EXC_THREAD  = 6'h00;
	localparam logic [5:0]  EXC_NMI     = 6'h02;
	localparam logic [5:0]  EXC_HARD    = 6'h03;
	localparam logic [5:0]  EXC_MEM     = 6'h04;
	localparam logic [5:0]  EXC_BUS     = 6'h05;
	localparam logic [5:0]  EXC_USAGE   = 6'h06;
	localparam logic [5:0]  EXC_SVC     = 6'h0B;
	localparam logic [5:0]  EXC_DEBUG   = 6'h0C;
	localparam logic [5:0]  EXC_PEND_SRV = 6'h0E;
	localparam logic [5:0]  EXC_SYSTICK = 6'h0F;

	// ==========================================================
	// Group levels: NMI above hard fault above every programmable level
	localparam logic [3:0]  LVL_NMI     = 4'h0;
	localparam logic [3:0]  LVL_HARD    = 4'h1;
	localparam logic [3:0]  LVL_PROG    = 4'h2;
	localparam logic [3:0]  LVL_NONE    = 4'hF;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0]  OFF_VTBL    = 8'h00;
	localparam logic [7:0]  OFF_GROUP   = 8'h04;
	localparam logic [7:0]  OFF_SYS_PRIO1 = 8'h08;
	localparam logic [7:0]  OFF_SYS_PRIO2 = 8'h0C;
	localparam logic [7:0]  OFF_IPRI0   = 8'h10;
	localparam logic [7:0]  OFF_IPRI7   = 8'h2C;
	localparam logic [7:0]  OFF_PEND    = 8'h30;
	localparam logic [7:0]  OFF_SEL     = 8'h34;

	// ==========================================================
	// Field layout and reset values
	localparam int          FLD_STRIDE  = 8;
	localparam logic [31:0] VTBL_MASK   = 32'h3FFFFF00;
	localparam logic [31:0] VTBL_RST    = 32'h00000000;
	localparam logic [1:0]  GROUP_RST   = 2'h0;
	localparam logic [2:0]  PRIO_RST    = 3'h0;
	localparam logic [29:0] IRQ_RSVD    = 30'h0C002300;
	localparam logic [1:0]  HTRANS_NSEQ = 2'h2;

endpackage

/* epvl_sync.sv */
// Two-stage synchroniser for asynchronous request lines
`timescale 1ns/1ps

module epvl_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_reset_n,
	// Data
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;
	logic [WIDTH-1:0] nxt_meta;
	logic [WIDTH-1:0] nxt_sync;

	// ==========================================================
	// Stage one feeds only stage two
	always_comb begin
		nxt_meta = i_async;
		nxt_sync = meta_ff;
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign o_sync = sync_ff;

endmodule

/* epvl_top_monitor.sv */
// Concurrent checks on the exception outputs of the priority and vector logic
`timescale 1ns/1ps

module epvl_top_monitor
	import epvl_pkg::*;
(
	// Clock and reset
	input  wire logic               i_clk,
	input  wire logic               i_reset_n,
	// Sources and core
	input  wire logic [NUM_IRQ-1:0] i_irq,
	input  wire logic               i_nmi,
	input  wire logic               i_hard_fault,
	input  wire logic [NUM_SYS-1:0] i_sys_pend,
	input  wire logic [5:0]         i_active_num,
	// Exception outputs
	input  wire logic               o_exc_valid,
	input  wire logic [5:0]         o_exc_num,
	input  wire logic [31:0]        o_exc_vector,
	input  wire logic               o_exc_preempt
);
	// ==========================================================
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	sequence s_quiet;
		!i_nmi && !i_hard_fault && i_sys_pend == 7'h00 && !o_exc_valid;
	endsequence
	sequence s_irq0_up;
		$rose(i_irq[0]) && i_irq[29:1] == 29'h0 ##0 s_quiet;
	endsequence
	sequence s_rsvd_up;
		$rose(i_irq[8]) && (i_irq & ~IRQ_RSVD) == 30'h0 ##0 s_quiet;
	endsequence
	a_reset_base: assert property ($rose(i_reset_n) |-> o_exc_vector == 32'h0 && !o_exc_valid)
		else $error("vector base not zero after reset");
	a_nmi_first: assert property (i_nmi |=> o_exc_valid && o_exc_num == EXC_NMI)
		else $error("pending nmi not selected");
	a_hard_next: assert property (i_hard_fault && !i_nmi |=> o_exc_num == EXC_HARD)
		else $error("pending hard fault not selected");
	a_vector_low: assert property (o_exc_vector[7:0] == {o_exc_num, 2'b00} && o_exc_vector[31:30] == 2'b00)
		else $error("vector address not base plus four times number");
	a_idle_zero: assert property (!o_exc_valid |-> o_exc_num == 6'h00 && !o_exc_preempt)
		else $error("idle outputs not cleared");
	a_thread_preempt: assert property (o_exc_valid && $past(i_active_num) == 6'h00 |-> o_exc_preempt)
		else $error("pending exception not offered in thread mode");
	a_nmi_held: assert property ($past(i_active_num) == EXC_NMI |-> !o_exc_preempt)
		else $error("nmi handler preempted");
	a_irq_sync: assert property (s_irq0_up |-> ##1 (!o_exc_valid)[*3] ##1 o_exc_valid)
		else $error("interrupt latency through synchroniser wrong");
	a_rsvd_quiet: assert property (s_rsvd_up |-> ##1 (!o_exc_valid)[*5])
		else $error("reserved interrupt became pending");
endmodule

bind epvl_top epvl_top_monitor u_mon (.i_clk, .i_reset_n, .i_irq, .i_nmi, .i_hard_fault, .i_sys_pend,
	.i_active_num, .o_exc_valid, .o_exc_num, .o_exc_vector, .o_exc_preempt);

/* epvl_core_model.sv */
// Behavioural core and peripheral sources facing the exception logic
`timescale 1ns/1ps

module epvl_core_model
	import epvl_pkg::*;
(
	// Clock and reset
	input  wire logic               i_clk,
	input  wire logic               i_reset_n,
	// Commands from the bench
	input  wire logic [NUM_IRQ-1:0] i_src,
	input  wire logic               i_accept,
	input  wire logic               i_ret,
	// Offer from the exception logic
	input  wire logic               i_exc_preempt,
	input  wire logic [5:0]         i_exc_num,
	input  wire logic [31:0]        i_exc_vector,
	// Towards the exception logic
	output logic      [NUM_IRQ-1:0] o_irq,
	output logic      [5:0]         o_active_num,
	output logic                    o_take,
	output logic      [5:0]         o_take_num,
	// Handler word fetched from the table
	output logic      [31:0]        o_entry
);
	// ==========================================================
	// Sources move off the clock edge so the synchroniser sees real skew
	assign #3 o_irq = i_src;
	// A handler is entered only when the offer may preempt
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_active_num <= 6'h00;
			o_take       <= 1'b0;
			o_take_num   <= 6'h00;
			o_entry      <= 32'h00000000;
		end else begin
			o_take <= 1'b0;
			if (i_accept && i_exc_preempt) begin
				o_take       <= 1'b1;
				o_take_num   <= i_exc_num;
				o_active_num <= i_exc_num;
				// Software fills each table word with bit zero set
				o_entry      <= {i_exc_vector[31:1], 1'b1};
			end else if (i_ret) begin
				o_active_num <= 6'h00;
			end
		end
	end
endmodule

/* epvl_top_test.sv */
// Self-checking bench of the exception priority and vector logic
`timescale 1ns/1ps

module epvl_top_test
	import epvl_pkg::*;
;
	// ==========================================================
	// Signals
	logic               i_clk, i_reset_n, i_hsel, i_hwrite, i_nmi, i_hard_fault, acc, ret, take;
	logic               o_hreadyout, o_hresp, o_exc_valid, o_exc_preempt;
	logic [31:0]        i_haddr, i_hwdata, o_hrdata, o_exc_vector, rd, entry;
	logic [1:0]         i_htrans;
	logic [NUM_IRQ-1:0] src, irq;
	logic [NUM_SYS-1:0] i_sys_pend;
	logic [5:0]         act, take_num, o_exc_num;
	int                 miscompares, comparisons, cycles;

	epvl_top uut (.i_clk, .i_reset_n, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize(3'h2), .i_hwdata,
		.i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp, .i_irq(irq), .i_nmi, .i_hard_fault,
		.i_sys_pend, .i_active_num(act), .i_take(take), .i_take_num(take_num), .o_exc_valid, .o_exc_num,
		.o_exc_vector, .o_exc_preempt);
	epvl_core_model core (.i_clk, .i_reset_n, .i_src(src), .i_accept(acc), .i_ret(ret),
		.i_exc_preempt(o_exc_preempt), .i_exc_num(o_exc_num), .o_irq(irq), .o_active_num(act),
		.o_take(take), .o_take_num(take_num), .i_exc_vector(o_exc_vector), .o_entry(entry));

	// ==========================================================
	// Shared tasks
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_hsel <= 1'b1; i_haddr <= {24'h0, a}; i_htrans <= HTRANS_NSEQ; i_hwrite <= w;
		do @(posedge i_clk); while (o_hreadyout !== 1'b1);
		i_hsel <= 1'b0; i_htrans <= 2'h0; i_hwdata <= d;
		do @(posedge i_clk); while (o_hreadyout !== 1'b1);
		rd = o_hrdata;
		chk("response", 32'h0, {31'h0, o_hresp});
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		chk("register", e, rd);
	endtask
	task automatic exc(input logic [5:0] n, input logic [31:0] b, input logic p);
		@(posedge i_clk);
		@(negedge i_clk);
		chk("valid", 32'h1, {31'h0, o_exc_valid});
		chk("number", {26'h0, n}, {26'h0, o_exc_num});
		chk("vector", b + {24'h0, n, 2'b00}, o_exc_vector);
		chk("preempt", {31'h0, p}, {31'h0, o_exc_preempt});
	endtask
	task automatic pulse(input logic r);
		@(posedge i_clk);
		if (r) ret <= 1'b1; else acc <= 1'b1;
		@(posedge i_clk);
		ret <= 1'b0; acc <= 1'b0;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_reset;
		for (int w = 0; w < 12; w++) rdc(8'(4 * w), 32'h0);
		ahb(1'b1, 8'h3C, 32'hA5A5A5A5);
		rdc(8'h3C, 32'h0);
		$display("test reset values done");
	endtask
	task automatic t_sys;
		logic [5:0] nums [7];
		nums = '{EXC_MEM, EXC_BUS, EXC_USAGE, EXC_SVC, EXC_DEBUG, EXC_PEND_SRV, EXC_SYSTICK};
		for (int i = 0; i < 7; i++) begin
			@(posedge i_clk); i_sys_pend <= 7'h01 << i;
			exc(nums[i], 32'h0, 1'b1);
		end
		@(posedge i_clk); i_sys_pend <= 7'h7F;
		exc(EXC_MEM, 32'h0, 1'b1);
		ahb(1'b1, OFF_SYS_PRIO1, 32'h1); exc(EXC_BUS, 32'h0, 1'b1);
		@(posedge i_clk); i_nmi <= 1'b1; i_hard_fault <= 1'b1;
		exc(EXC_NMI, 32'h0, 1'b1);
		pulse(1'b0);
		@(posedge i_clk); i_nmi <= 1'b0;
		chk("handler entry", 32'h9, entry);
		exc(EXC_HARD, 32'h0, 1'b0);
		pulse(1'b1); exc(EXC_HARD, 32'h0, 1'b1);
		@(posedge i_clk); i_hard_fault <= 1'b0; i_sys_pend <= 7'h00;
		ahb(1'b1, OFF_SYS_PRIO1, 32'h0);
		$display("test system exceptions done");
	endtask
	task automatic t_vec;
		ahb(1'b1, OFF_VTBL, 32'hFFFFFFFF); rdc(OFF_VTBL, 32'h3FFFFF00);
		ahb(1'b1, OFF_VTBL, 32'h12345678); rdc(OFF_VTBL, 32'h12345600);
		@(posedge i_clk); src <= 30'h1;
		repeat (3) @(posedge i_clk);
		exc(IRQ_BASE, 32'h12345600, 1'b1);
		@(posedge i_clk); src <= 30'h0; i_reset_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_reset_n <= 1'b1;
		rdc(OFF_VTBL, 32'h0);
		chk("vector after reset", 32'h0, o_exc_vector);
		$display("test vector table done");
	endtask
	task automatic t_rsvd;
		@(posedge i_clk); src <= IRQ_RSVD;
		repeat (6) @(posedge i_clk);
		chk("reserved valid", 32'h0, {31'h0, o_exc_valid});
		rdc(OFF_PEND, 32'h0);
		@(posedge i_clk); src <= 30'h0;
		$display("test reserved interrupts done");
	endtask
	task automatic t_order;
		@(posedge i_clk); src <= 30'h3;
		repeat (3) @(posedge i_clk);
		exc(IRQ_BASE, 32'h0, 1'b1);
		ahb(1'b1, OFF_IPRI0, 32'h3); exc(6'h11, 32'h0, 1'b1);
		@(posedge i_clk); src <= 30'h0;
		repeat (3) @(posedge i_clk);
		// The taken request stays pending one more edge until the take clears it
		pulse(1'b0); @(posedge i_clk); exc(IRQ_BASE, 32'h0, 1'b0);
		ahb(1'b1, OFF_IPRI0, 32'h0); exc(IRQ_BASE, 32'h0, 1'b0);
		ahb(1'b1, OFF_IPRI0, 32'h100); ahb(1'b1, OFF_GROUP, 32'h1);
		exc(IRQ_BASE, 32'h0, 1'b0);
		ahb(1'b1, OFF_GROUP, 32'h0); exc(IRQ_BASE, 32'h0, 1'b1);
		pulse(1'b1);
		@(posedge i_clk); src <= 30'h4;
		ahb(1'b1, OFF_IPRI0, 32'h00020003); ahb(1'b1, OFF_GROUP, 32'h1);
		exc(6'h12, 32'h0, 1'b1);
		rdc(OFF_SEL, 32'h000000D2);
		@(posedge i_clk); src <= 30'h0;
		$display("test priority order done");
	endtask

	// ==========================================================
	// Run control
	task automatic conclude;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 4000) begin
			miscompares++;
			conclude;
		end
	end
	initial begin
		i_reset_n = 1'b0; i_hsel = 1'b0; i_haddr = 32'h0; i_htrans = 2'h0; i_hwrite = 1'b0;
		i_hwdata = 32'h0; i_nmi = 1'b0; i_hard_fault = 1'b0; i_sys_pend = 7'h00; src = 30'h0;
		acc = 1'b0; ret = 1'b0; miscompares = 0; comparisons = 0; cycles = 0;
		repeat (8) @(posedge i_clk);
		i_reset_n <= 1'b1;
		t_reset;
		t_sys;
		t_vec;
		t_rsvd;
		t_order;
		conclude;
	end
endmodule
